// [rtl/pdr_regs.vh]
`ifndef PDR_REGS_VH
`define PDR_REGS_VH
// Port-relative byte offsets
`define PDR_OFF_CABLE 12'h124
`define PDR_OFF_LINK 12'h126
`define PDR_OFF_SYMERR 12'h12A
`define PDR_OFF_IRQ 12'h136
// Cable test register fields
`define PDR_CT_EN_BIT 15
`define PDR_CT_RSV14_BIT 14
`define PDR_CT_PAIR_HI 13
`define PDR_CT_PAIR_LO 12
`define PDR_CT_RSV_HI 11
`define PDR_CT_RSV_LO 10
`define PDR_CT_RES_HI 9
`define PDR_CT_RES_LO 8
// Cable result codes
`define PDR_RES_OK 2'h0
`define PDR_RES_OPEN 2'h1
`define PDR_RES_SHORT 2'h2
// Link status fields
`define PDR_LS_GIG_BIT 1
`define PDR_LS_FE_BIT 0
// Interrupt register fields
`define PDR_IRQ_EN_HI 15
`define PDR_IRQ_EN_LO 8
`define PDR_IRQ_ST_HI 7
`define PDR_IRQ_ST_LO 0
// Reset values
`define PDR_RST_CABLE 16'h0000
`define PDR_RST_COUNT 16'h0000
`define PDR_RST_IRQ 8'h00
// Cable test duration
`define PDR_CT_TIME_NS 2000
`define PDR_CT_CYCLES ((`PDR_CT_TIME_NS + 7) / 8)
`endif

// [rtl/pdr_cable_test.v]
`timescale 1ns/1ns
`default_nettype none
`include "pdr_regs.vh"
// Sequencer of one cable diagnostic run
module pdr_cable_test #(
  parameter CYCLES = `PDR_CT_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire start,
  input wire abort,
  // Result from the measurement front end
  input wire open_flt,
  input wire short_flt,
  // Status
  output reg busy_q,
  output reg [1:0] result_q
);
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [31:0] cnt_q;

  // Next state; abort wins over completion
  always @* begin
    case (state_q)
      ST_IDLE: state_d = start ? ST_RUN : ST_IDLE;
      ST_RUN: state_d = (abort || cnt_q == CYCLES - 1) ? ST_IDLE : ST_RUN;
      default: state_d = ST_IDLE;
    endcase
  end

  // State, timer, result latch
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 32'h0;
      busy_q <= 1'b0;
      result_q <= `PDR_RES_OK;
    end else begin
      state_q <= state_d;
      busy_q <= (state_d == ST_RUN);
      cnt_q <= (state_q == ST_RUN) ? cnt_q + 32'h1 : 32'h0;
      // Short dominates open; code 11 never produced
      if (state_q == ST_RUN && state_d == ST_IDLE && !abort) begin
        result_q <= short_flt ? `PDR_RES_SHORT : (open_flt ? `PDR_RES_OPEN : `PDR_RES_OK);
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/pdr_port_regs.v]
`timescale 1ns/1ns
`default_nettype none
`include "pdr_regs.vh"
module pdr_port_regs #(
  parameter CT_CYCLES = `PDR_CT_CYCLES
) (
  // Clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  // Register port
  input wire [11:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  // Cable test front end
  input wire CT_OPEN_FAULT,
  input wire CT_SHORT_FAULT,
  output reg CT_RUN,
  output reg [1:0] CT_PAIR,
  // Link state pins
  input wire LINK_GIG_UP,
  input wire LINK_FE_UP,
  // Receive symbol error frame pulse
  input wire RX_SYMBOL_ERROR_FRAME,
  // Event pulses: jabber, rxerr, page, pdf, lpack, down, rfault, up
  input wire [7:0] EVENTS,
  // Interrupt output
  output reg IRQ
);
  // Pin synchronisers
  reg [1:0] gig_s1_q;
  reg [1:0] gig_s2_q;
  reg [7:0] ev_s1_q;
  reg [7:0] ev_s2_q;
  reg [7:0] ev_s3_q;
  reg sym_s1_q;
  reg sym_s2_q;
  reg sym_s3_q;
  // Registers
  reg [1:0] pair_q;
  reg rsv14_q;
  reg [1:0] rsv_q;
  reg [15:0] count_q;
  reg [7:0] irq_en_q;
  reg [7:0] irq_st_q;
  reg [15:0] rdata_d;
  wire ct_busy;
  wire [1:0] ct_result;
  wire wr_cable;
  wire rd_count;
  wire rd_irq;
  wire ct_start;
  wire ct_abort;
  wire [7:0] ev_rise;
  wire sym_rise;

  // Address match helper
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  assign wr_cable = WR && hit(ADDR, `PDR_OFF_CABLE);
  assign rd_count = RD && hit(ADDR, `PDR_OFF_SYMERR);
  assign rd_irq = RD && hit(ADDR, `PDR_OFF_IRQ);
  // Start only from idle so a rewrite does not restart a run
  assign ct_start = wr_cable && WDATA[`PDR_CT_EN_BIT] && !ct_busy;
  assign ct_abort = wr_cable && !WDATA[`PDR_CT_EN_BIT];

  // Two-flop synchronisers, third stage for edges
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      gig_s1_q <= 2'h0;
      gig_s2_q <= 2'h0;
      ev_s1_q <= 8'h00;
      ev_s2_q <= 8'h00;
      ev_s3_q <= 8'h00;
      sym_s1_q <= 1'b0;
      sym_s2_q <= 1'b0;
      sym_s3_q <= 1'b0;
    end else begin
      gig_s1_q <= {LINK_GIG_UP, LINK_FE_UP};
      gig_s2_q <= gig_s1_q;
      ev_s1_q <= EVENTS;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
      sym_s1_q <= RX_SYMBOL_ERROR_FRAME;
      sym_s2_q <= sym_s1_q;
      sym_s3_q <= sym_s2_q;
    end
  end

  // Edges only, so a slow pin counts once
  assign ev_rise = ev_s2_q & ~ev_s3_q;
  assign sym_rise = sym_s2_q & ~sym_s3_q;

  pdr_cable_test #(
    .CYCLES(CT_CYCLES)
  ) u_ct (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .start(ct_start),
    .abort(ct_abort),
    .open_flt(CT_OPEN_FAULT),
    .short_flt(CT_SHORT_FAULT),
    .busy_q(ct_busy),
    .result_q(ct_result)
  );

  // Control and counters
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pair_q <= 2'h0;
      rsv14_q <= 1'b0;
      rsv_q <= 2'h0;
      count_q <= `PDR_RST_COUNT;
      irq_en_q <= `PDR_RST_IRQ;
      irq_st_q <= `PDR_RST_IRQ;
    end else begin
      if (wr_cable) begin
        pair_q <= WDATA[`PDR_CT_PAIR_HI:`PDR_CT_PAIR_LO];
        rsv14_q <= WDATA[`PDR_CT_RSV14_BIT];
        rsv_q <= WDATA[`PDR_CT_RSV_HI:`PDR_CT_RSV_LO];
      end
      if (WR && hit(ADDR, `PDR_OFF_IRQ)) begin
        irq_en_q <= WDATA[`PDR_IRQ_EN_HI:`PDR_IRQ_EN_LO];
      end
      // A frame arriving with the clearing read counts as one
      if (rd_count) begin
        count_q <= {15'h0000, sym_rise};
      end else if (sym_rise && count_q != 16'hFFFF) begin
        count_q <= count_q + 16'h0001;
      end
      // Set wins over read clear
      irq_st_q <= (rd_irq ? 8'h00 : irq_st_q) | ev_rise;
    end
  end

  // Read mux
  always @* begin
    rdata_d = 16'h0000;
    case (ADDR)
      `PDR_OFF_CABLE: begin
        rdata_d[`PDR_CT_EN_BIT] = ct_busy;
        rdata_d[`PDR_CT_RSV14_BIT] = rsv14_q;
        rdata_d[`PDR_CT_PAIR_HI:`PDR_CT_PAIR_LO] = pair_q;
        rdata_d[`PDR_CT_RSV_HI:`PDR_CT_RSV_LO] = rsv_q;
        rdata_d[`PDR_CT_RES_HI:`PDR_CT_RES_LO] = ct_result;
      end
      `PDR_OFF_LINK: begin
        rdata_d[`PDR_LS_GIG_BIT] = gig_s2_q[1];
        rdata_d[`PDR_LS_FE_BIT] = gig_s2_q[0];
      end
      `PDR_OFF_SYMERR: rdata_d = count_q;
      `PDR_OFF_IRQ: rdata_d = {irq_en_q, irq_st_q};
      default: rdata_d = 16'h0000;
    endcase
  end

  // Registered outputs
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 16'h0000;
      CT_RUN <= 1'b0;
      CT_PAIR <= 2'h0;
      IRQ <= 1'b0;
    end else begin
      RDATA <= RD ? rdata_d : 16'h0000;
      CT_RUN <= ct_busy;
      CT_PAIR <= pair_q;
      IRQ <= |(irq_en_q & irq_st_q);
    end
  end
endmodule
`default_nettype wire

// [bench/pdr_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
// Cable run and irq timing, watched at the pins
module pdr_monitor #(
  parameter CT_CYCLES = 250
) (
  // Clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  // Register port and outputs
  input wire [11:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [15:0] RDATA,
  input wire CT_RUN,
  input wire IRQ
);
  localparam int RMAX = CT_CYCLES + 2;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // Decoded accesses
  wire wct = WR && ADDR == 12'h124;
  wire rct = RD && ADDR == 12'h124;
  wire go = wct && WDATA[15] && !CT_RUN;
  wire acc = (WR || RD) && ADDR == 12'h136;
  a_run_start: assert property (go |-> ##[1:2] CT_RUN) else $error("no start");
  a_run_ends: assert property ($rose(CT_RUN) |-> ##[1:RMAX] !CT_RUN) else $error("no end");
  a_run_abort: assert property (wct && !WDATA[15] |-> ##[1:2] !CT_RUN) else $error("no abort");
  a_abort_read: assert property (wct && !WDATA[15] ##1 rct |=> !RDATA[15]) else $error("busy");
  a_busy_read: assert property (go ##1 rct |=> RDATA[15]) else $error("idle");
  a_no_code3: assert property (rct |=> RDATA[9:8] != 2'h3) else $error("code");
  a_link_rsvd: assert property (RD && ADDR == 12'h126 |=> RDATA[15:2] == 14'h0000) else $error("link");
  a_irq_fall: assert property ($fell(IRQ) |-> $past(acc) || $past(acc, 2)) else $error("irq");
  cover property (go);
  cover property ($fell(CT_RUN));
  cover property ($rose(IRQ));
endmodule
bind pdr_port_regs pdr_monitor #(.CT_CYCLES(CT_CYCLES)) pdr_monitor_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CT_RUN(CT_RUN), .IRQ(IRQ));
`default_nettype wire

// [bench/test_phy_diag_status_irq_regs.sv]
`timescale 1ns/1ns
`default_nettype none
module test_phy_diag_status_irq_regs;
  reg clk = 0, rst_n = 0, wr = 0, rd = 0, op = 0, sh = 0, gig = 0, fe = 0, sym = 0;
  reg [11:0] a = 0;
  reg [15:0] d = 0;
  reg [7:0] ev = 0;
  reg [1:0] res = 0;
  wire [15:0] q;
  wire irq;
  wire ct_run;
  wire [1:0] ct_pair;
  integer n_mismatch = 0, samples_checked = 0, cyc = 0, i;
  pdr_port_regs #(.CT_CYCLES(10)) pdr_port_regs_inst (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(a), .WDATA(d),
    .WR(wr), .RD(rd), .RDATA(q), .CT_OPEN_FAULT(op), .CT_SHORT_FAULT(sh), .CT_RUN(ct_run), .CT_PAIR(ct_pair),
    .LINK_GIG_UP(gig), .LINK_FE_UP(fe), .RX_SYMBOL_ERROR_FRAME(sym), .EVENTS(ev), .IRQ(irq));
  // Clock, and a guard against hangs
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      final_report;
    end
  end
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input [39:0] n, input [15:0] e, s);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %0s exp %h got %h", n, e, s);
    end
  endtask
  // One-cycle strobes; read data only in the next cycle
  task wr_reg(input [11:0] ad, input [15:0] v);
    a <= ad;
    d <= v;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task rd_reg(input [11:0] ad, input [15:0] e);
    a <= ad;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(posedge clk);
    chk("RDATA", e, q);
  endtask
  // Reset value, unmapped place, every pair
  task t_regs;
    rd_reg(12'h136, 16'h0000);
    wr_reg(12'h128, 16'hFFFF);
    rd_reg(12'h128, 16'h0000);
    for (i = 0; i < 4; i++) begin
      wr_reg(12'h124, {2'h0, i[1:0], 12'hC00});
      rd_reg(12'h124, {2'h0, i[1:0], 12'hC00});
      chk("PAIR", {14'h0000, i[1:0]}, {14'h0000, ct_pair});
    end
  endtask
  // Clean, open, short (short wins), then abort keeps old result
  task t_cable;
    for (i = 0; i < 3; i++) begin
      op <= i > 0;
      sh <= i == 2;
      wr_reg(12'h124, 16'h9000);
      rd_reg(12'h124, {6'h24, res, 8'h00});
      chk("CT_RUN", 16'h0001, {15'h0000, ct_run});
      repeat (12) @(posedge clk);
      res = i[1:0];
      rd_reg(12'h124, {6'h04, res, 8'h00});
      chk("CT_RUN", 16'h0000, {15'h0000, ct_run});
    end
    wr_reg(12'h124, 16'h9000);
    @(posedge clk);
    wr_reg(12'h124, 16'h1000);
    rd_reg(12'h124, {6'h04, res, 8'h00});
  endtask
  // Link pins pass a synchroniser, so allow it to settle
  task t_stat;
    for (i = 0; i < 4; i++) begin
      {gig, fe} <= i[1:0];
      repeat (4) @(posedge clk);
      rd_reg(12'h126, {14'h0000, i[1:0]});
    end
    for (i = 0; i < 3; i++) begin
      sym <= 1;
      repeat (3) @(posedge clk);
      sym <= 0;
      repeat (3) @(posedge clk);
    end
    rd_reg(12'h12A, 16'h0003);
    rd_reg(12'h12A, 16'h0000);
  endtask
  // Odd events masked; a stale bit would show in the next check
  task t_irq;
    wr_reg(12'h136, 16'h5500);
    for (i = 0; i < 8; i++) begin
      ev <= 8'h01 << i;
      repeat (2) @(posedge clk);
      ev <= 8'h00;
      repeat (4) @(posedge clk);
      chk("IRQ", {15'h0000, !i[0]}, {15'h0000, irq});
      rd_reg(12'h136, 16'h5500 | (16'h0001 << i));
    end
    // Event edge lands on the clearing read; set must win
    ev <= 8'h01;
    repeat (2) @(posedge clk);
    rd_reg(12'h136, 16'h5500);
    ev <= 8'h00;
    @(posedge clk);
    chk("IRQ", 16'h0001, {15'h0000, irq});
    rd_reg(12'h136, 16'h5501);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    t_regs;
    t_cable;
    t_stat;
    t_irq;
    final_report;
  end
endmodule
`default_nettype wire
